// file: inc/monitor_mux_map.svh
`ifndef MONITOR_MUX_MAP_SVH
`define MONITOR_MUX_MAP_SVH
// channel and step geometry
`define CHAN_COUNT 4
`define STEP_WIDTH 4
`define STEP_NONE 4'h0
`define STEP_FIRST 4'h1
// three-level pin encodings
`define TRI_LOW 2'h0
`define TRI_FLOAT 2'h1
`define TRI_HIGH 2'h2
// select timeout, reset period in ns and its cycle count at 10 ns
`define CLK_PERIOD_NS 10
`define RESET_PERIOD_NS 100000
`define RESET_PERIOD_CYCLES (`RESET_PERIOD_NS / `CLK_PERIOD_NS)
`define TIMEOUT_WIDTH 16
`endif

// file: inc/monitor_mux_pkg.sv
package monitor_mux_pkg;
   typedef enum logic [2:0] {
      ST_IDLE = 3'h1,
      ST_BUS = 3'h2,
      ST_SHUNT = 3'h4
   } seq_state_type;
   typedef enum logic [1:0] {
      TRI_LOW = 2'h0,
      TRI_FLOAT = 2'h1,
      TRI_HIGH = 2'h2
   } tri_level_type;
endpackage : monitor_mux_pkg

// file: hw/bus_valid_logic.sv
`timescale 1ns/1ns
`include "monitor_mux_map.svh"
module bus_valid_logic (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // conditions
   input wire logic supply_ok,
   input wire logic enable_high,
   input wire logic bypass_n,
   input wire logic [`CHAN_COUNT-1:0] above_ref,
   // open-drain flag
   output logic flag_oe
);
   typedef struct packed {
      logic oe;
   } bv_state_type;
   bv_state_type state;
   bv_state_type next_state;
   // pull low unless supply is good, enable is not high and either bypassed or every input is above the reference
   always_comb begin
      next_state = state;
      next_state.oe = 1'b1;
      if (supply_ok && !enable_high) begin
         if (!bypass_n) begin
            next_state.oe = 1'b0;
         end else if (&above_ref) begin
            next_state.oe = 1'b0;
         end
      end
   end
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= '{oe: 1'b1};
      end else begin
         state <= next_state;
      end
   end
   assign flag_oe = state.oe;
   chk_bypass_release: assert property (@(posedge core_clk) disable iff (!rst_n)
      (supply_ok && !enable_high && !bypass_n) |=> !flag_oe)
      else $error("flag not released under bypass");
   chk_hold_low: assert property (@(posedge core_clk) disable iff (!rst_n)
      (bypass_n && !(&above_ref)) |=> flag_oe)
      else $error("flag released with input below reference");
endmodule : bus_valid_logic

// file: hw/monitor_mux_control.sv
`timescale 1ns/1ns
`include "monitor_mux_map.svh"
// Operation
// - floating shunt output skips it and higher
// - unused bus inputs still gate flag
// - bypass low ignores comparisons, releases flag when supply good and enable not high
// - enable floating: limited, output off, reset
// - enable high: standby, divider ground off
// - role pin: low A, float alone, high B
// - flag low until all inputs above ref
// - steps bus then shunt, wraps to one
// - select held past reset period resets
module monitor_mux_control (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // step select and mode pins
   input wire logic step_select_input,
   input wire logic [1:0] enable_level,
   input wire logic [1:0] role_level,
   input wire logic bypass_n,
   input wire logic supply_ok,
   // per channel sensing
   input wire logic [`CHAN_COUNT-1:0] shunt_output_present,
   input wire logic [`CHAN_COUNT-1:0] bus_above_ref,
   // outputs
   output logic diff_output_enable,
   output logic [1:0] out_channel,
   output logic out_is_shunt,
   output logic divider_ground_switch,
   output logic bandgap_ref_valid,
   output logic bus_valid_flag_oe
);
   typedef struct packed {
      monitor_mux_pkg::seq_state_type seq;
      logic [2:0] slot;
      logic partner;
      logic sel_prev;
      logic [`TIMEOUT_WIDTH-1:0] idle_count;
      logic drive;
      logic [1:0] chan;
      logic shunt;
      logic gnd;
      logic ref_ok;
   } ctl_state_type;
   ctl_state_type state;
   ctl_state_type next_state;
   logic [2:0] active;
   logic paired;
   logic full_on;
   logic edge_seen;
   logic slot_last;
   logic timed_out;
   // count of active channels: stops at first floating shunt output
   always_comb begin
      active = 3'h0;
      if (shunt_output_present[0]) begin
         active = 3'h1;
         if (shunt_output_present[1]) begin
            active = 3'h2;
            if (shunt_output_present[2]) begin
               active = 3'h3;
               if (shunt_output_present[3]) begin
                  active = 3'h4;
               end
            end
         end
      end
   end
   assign paired = (role_level != `TRI_FLOAT);
   assign full_on = (enable_level == `TRI_LOW);
   assign edge_seen = step_select_input && !state.sel_prev;
   assign slot_last = (state.slot == active - 3'h1);
   // level held past the reset period; any change in this cycle blocks it, so no rising edge is lost
   assign timed_out = (state.idle_count == `TIMEOUT_WIDTH'(`RESET_PERIOD_CYCLES)) &&
      (step_select_input == state.sel_prev);
   // sequencer
   always_comb begin
      next_state = state;
      next_state.sel_prev = step_select_input;
      next_state.gnd = (enable_level != `TRI_HIGH);
      next_state.ref_ok = 1'b1;
      if (step_select_input != state.sel_prev) begin
         next_state.idle_count = '0;
      end else if (state.idle_count != `TIMEOUT_WIDTH'(`RESET_PERIOD_CYCLES)) begin
         next_state.idle_count = state.idle_count + `TIMEOUT_WIDTH'(1);
      end
      if (!full_on || active == 3'h0) begin
         next_state.seq = monitor_mux_pkg::ST_IDLE;
         next_state.slot = 3'h0;
         next_state.partner = 1'b0;
      end else if (timed_out) begin
         next_state.seq = monitor_mux_pkg::ST_IDLE;
         next_state.slot = 3'h0;
         next_state.partner = 1'b0;
      end else if (edge_seen) begin
         unique case (state.seq)
            monitor_mux_pkg::ST_IDLE: begin
               next_state.seq = monitor_mux_pkg::ST_BUS;
               next_state.slot = 3'h0;
               next_state.partner = 1'b0;
            end
            monitor_mux_pkg::ST_BUS: begin
               next_state.seq = monitor_mux_pkg::ST_SHUNT;
            end
            monitor_mux_pkg::ST_SHUNT: begin
               next_state.seq = monitor_mux_pkg::ST_BUS;
               if (!slot_last) begin
                  next_state.slot = state.slot + 3'h1;
               end else begin
                  next_state.slot = 3'h0;
                  if (paired) begin
                     next_state.partner = !state.partner;
                  end
               end
            end
            default: begin
               next_state.seq = monitor_mux_pkg::ST_IDLE;
            end
         endcase
      end
      // drive only in own half: device A first, B second
      next_state.drive = (next_state.seq != monitor_mux_pkg::ST_IDLE) &&
         (!paired || (next_state.partner == (role_level == `TRI_HIGH)));
      next_state.chan = next_state.slot[1:0];
      next_state.shunt = (next_state.seq == monitor_mux_pkg::ST_SHUNT);
   end
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= '{seq: monitor_mux_pkg::ST_IDLE, slot: 3'h0, partner: 1'b0,
            sel_prev: 1'b0, idle_count: '0, drive: 1'b0, chan: 2'h0,
            shunt: 1'b0, gnd: 1'b0, ref_ok: 1'b1};
      end else begin
         state <= next_state;
      end
   end
   assign diff_output_enable = state.drive;
   assign out_channel = state.chan;
   assign out_is_shunt = state.shunt;
   assign divider_ground_switch = state.gnd;
   assign bandgap_ref_valid = state.ref_ok;
   // flag logic sees every bus input, used or not
   bus_valid_logic u_flag (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .supply_ok(supply_ok),
      .enable_high(enable_level == `TRI_HIGH),
      .bypass_n(bypass_n),
      .above_ref(bus_above_ref),
      .flag_oe(bus_valid_flag_oe)
   );
   sequence s_not_full;
      enable_level != `TRI_LOW;
   endsequence
   chk_limited_off: assert property (@(posedge core_clk) disable iff (!rst_n)
      s_not_full |=> !diff_output_enable)
      else $error("output driven while not fully enabled");
   chk_standby_ground: assert property (@(posedge core_clk) disable iff (!rst_n)
      (enable_level == `TRI_HIGH) |=> !divider_ground_switch)
      else $error("divider ground on in standby");
   chk_channel_skip: assert property (@(posedge core_clk) disable iff (!rst_n)
      diff_output_enable |-> ({1'b0, out_channel} < active))
      else $error("skipped channel presented");
   chk_bus_then_shunt: assert property (@(posedge core_clk) disable iff (!rst_n)
      (full_on && active != 3'h0 && edge_seen && state.seq == monitor_mux_pkg::ST_BUS
       && state.idle_count != `TIMEOUT_WIDTH'(`RESET_PERIOD_CYCLES)) |=> out_is_shunt)
      else $error("shunt did not follow bus step");
   chk_timeout_reset: assert property (@(posedge core_clk) disable iff (!rst_n)
      timed_out |=> !diff_output_enable)
      else $error("sequencer not reset after timeout");
   chk_partner_off: assert property (@(posedge core_clk) disable iff (!rst_n)
      (paired && state.partner != (role_level == `TRI_HIGH)) |-> !diff_output_enable)
      else $error("output driven in partner step");
   chk_standalone_role: assert property (@(posedge core_clk) disable iff (!rst_n)
      (role_level == `TRI_FLOAT) |-> !state.partner)
      else $error("stand-alone device entered partner half");
   chk_unused_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
      (supply_ok && enable_level != `TRI_HIGH && bypass_n && !(&bus_above_ref))
      |=> bus_valid_flag_oe)
      else $error("unused input ignored by flag");
   // a step pulse that the sequencer takes while in the shunt phase
   sequence s_shunt_step;
      full_on && active != 3'h0 && edge_seen && state.seq == monitor_mux_pkg::ST_SHUNT;
   endsequence
   chk_shunt_to_bus: assert property (@(posedge core_clk) disable iff (!rst_n)
      s_shunt_step |=> !out_is_shunt)
      else $error("bus step did not follow shunt step");
   chk_wrap_first: assert property (@(posedge core_clk) disable iff (!rst_n)
      s_shunt_step ##0 slot_last |=> (out_channel == 2'h0 && !out_is_shunt))
      else $error("sequence did not wrap to first channel");
   chk_float_ground: assert property (@(posedge core_clk) disable iff (!rst_n)
      (enable_level == `TRI_FLOAT) |=> divider_ground_switch)
      else $error("divider ground off while limited");
   // without a step or timeout the presented measurement stays put
   chk_step_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
      (full_on && active != 3'h0 && !edge_seen && !timed_out)
      |=> ($stable(out_channel) && $stable(out_is_shunt) && $stable(diff_output_enable)))
      else $error("output moved without a step");
endmodule : monitor_mux_control

// file: test/step_pulser.sv
`timescale 1ns/1ns
// external controller that pulses the step select pin
module step_pulser (
   // clock
   input wire logic core_clk,
   // step select pin
   output logic step_select_input
);
   initial step_select_input = 1'b0;
   // two cycles high then two low, so every rise has a low cycle before it
   task automatic pulse();
      @(posedge core_clk) step_select_input <= 1'b1;
      repeat (2) @(posedge core_clk);
      step_select_input <= 1'b0;
      repeat (2) @(posedge core_clk);
   endtask : pulse
endmodule : step_pulser

// file: test/tb_monitor_mux_mode_control.sv
`timescale 1ns/1ns
`include "monitor_mux_map.svh"
module tb_monitor_mux_mode_control;
   logic core_clk, rst_n, step_select_input, bypass_n, supply_ok;
   logic [1:0] enable_level, role_level, out_channel;
   logic [`CHAN_COUNT-1:0] shunt_output_present, bus_above_ref;
   logic diff_output_enable, out_is_shunt, divider_ground_switch;
   logic bandgap_ref_valid, bus_valid_flag_oe;
   int miscompares = 0;
   int check_count = 0;
   // design and step controller
   monitor_mux_control dut_u (.core_clk(core_clk), .rst_n(rst_n),
      .step_select_input(step_select_input), .enable_level(enable_level),
      .role_level(role_level), .bypass_n(bypass_n), .supply_ok(supply_ok),
      .shunt_output_present(shunt_output_present), .bus_above_ref(bus_above_ref),
      .diff_output_enable(diff_output_enable), .out_channel(out_channel),
      .out_is_shunt(out_is_shunt), .divider_ground_switch(divider_ground_switch),
      .bandgap_ref_valid(bandgap_ref_valid), .bus_valid_flag_oe(bus_valid_flag_oe));
   step_pulser pulser_u (.core_clk(core_clk), .step_select_input(step_select_input));
   // 100 MHz clock
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   task automatic cmp(input string what, input logic [3:0] exp, input logic [3:0] got);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp
   // reset for three cycles with the given pin setup, then let the flag settle
   task automatic restart(input logic [1:0] en, role, input logic [3:0] pres, abv);
      @(posedge core_clk);
      {enable_level, role_level, shunt_output_present} <= {en, role, pres};
      {bus_above_ref, bypass_n, supply_ok, rst_n} <= {abv, 3'h6};
      repeat (3) @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge core_clk);
   endtask : restart
   // step through one full round plus two steps and check who drives and what is shown
   task automatic run_seq(input logic [1:0] role, input logic [3:0] pres, input int act);
      int pos, span;
      logic drv;
      logic [3:0] exp_step;
      restart(2'h0, role, pres, 4'hF);
      span = (role == 2'h1) ? 2 * act : 4 * act;
      for (int n = 0; n < span + 2; n++) begin
         pulser_u.pulse();
         pos = n % span;
         drv = (role == 2'h1) || ((pos >= 2 * act) == (role == 2'h2));
         exp_step = {1'b0, 2'(pos % (2 * act) / 2), 1'(pos % 2)};
         cmp("drive", {3'h0, drv}, {3'h0, diff_output_enable});
         if (drv) cmp("step", exp_step, {1'b0, out_channel, out_is_shunt});
      end
   endtask : run_seq
   task automatic test_enable();
      restart(2'h1, 2'h1, 4'hF, 4'hF);
      pulser_u.pulse();
      cmp("float out", 4'h0, {3'h0, diff_output_enable});
      cmp("float gnd", 4'h3, {2'h0, divider_ground_switch, bandgap_ref_valid});
      cmp("float flag", 4'h0, {3'h0, bus_valid_flag_oe});
      enable_level <= 2'h0;
      pulser_u.pulse();
      cmp("first", 4'h8, {diff_output_enable, out_channel, out_is_shunt});
      enable_level <= 2'h2;
      repeat (2) @(posedge core_clk);
      cmp("standby", 4'h0, {2'h0, diff_output_enable, divider_ground_switch});
      cmp("standby flag", 4'h1, {3'h0, bus_valid_flag_oe});
      cmp("standby ref", 4'h1, {3'h0, bandgap_ref_valid});
   endtask : test_enable
   task automatic test_flag();
      restart(2'h0, 2'h1, 4'h3, 4'h7);
      cmp("unused low", 4'h1, {3'h0, bus_valid_flag_oe});
      bus_above_ref <= 4'hF;
      repeat (2) @(posedge core_clk);
      cmp("all above", 4'h0, {3'h0, bus_valid_flag_oe});
      {bypass_n, bus_above_ref} <= 5'h00;
      repeat (2) @(posedge core_clk);
      cmp("bypass", 4'h0, {3'h0, bus_valid_flag_oe});
      supply_ok <= 1'b0;
      repeat (2) @(posedge core_clk);
      cmp("no supply", 4'h1, {3'h0, bus_valid_flag_oe});
   endtask : test_flag
   task automatic test_timeout();
      restart(2'h0, 2'h1, 4'hF, 4'hF);
      pulser_u.pulse();
      repeat (`RESET_PERIOD_CYCLES - 10) @(posedge core_clk);
      cmp("before", 4'h1, {3'h0, diff_output_enable});
      repeat (20) @(posedge core_clk);
      cmp("after", 4'h0, {3'h0, diff_output_enable});
      pulser_u.pulse();
      cmp("resume", 4'h8, {diff_output_enable, out_channel, out_is_shunt});
   endtask : test_timeout
   task automatic print_verdict();
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : print_verdict
   // watchdog well past the expected run length
   initial begin
      repeat (40000) @(posedge core_clk);
      miscompares++;
      print_verdict();
   end
   // main sequence
   initial begin
      {rst_n, bypass_n, supply_ok, enable_level, role_level} = 7'h06;
      {shunt_output_present, bus_above_ref} = 8'hFF;
      run_seq(2'h1, 4'hF, 4);
      run_seq(2'h1, 4'h3, 2);
      run_seq(2'h0, 4'h7, 3);
      run_seq(2'h2, 4'h7, 3);
      test_enable();
      test_flag();
      test_timeout();
      print_verdict();
   end
endmodule : tb_monitor_mux_mode_control
